// File: gpio_ports.sv
// Low-voltage ports A, B, D and open-collector port C with register file
`timescale 1ns/1ps
`default_nettype none
module gpio_ports #(
	parameter int HV_W = 4
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// CPU I/O bus
	input wire logic [5:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic io_bit_set_i,
	input wire logic io_bit_clr_i,
	input wire logic [2:0] io_bit_i,
	output logic [7:0] io_rdata_o,
	// Core control register contents
	output logic [7:0] core_control_o,
	// Port A pads
	input wire logic [7:0] pa_in_i,
	output io_pkg::pin_drive_t pa_drive_o,
	// Port B pads
	input wire logic [7:0] pb_in_i,
	output io_pkg::pin_drive_t pb_drive_o,
	// Port D pads
	input wire logic [1:0] pd_in_i,
	output io_pkg::pin_drive_t pd_drive_o,
	// Port C open-collector pads
	output logic [HV_W-1:0] pc_out_o,
	output logic [HV_W-1:0] pc_oe_o,
	// Test access controller
	input wire logic test_access_enable_i,
	input wire logic instruction_shift_state_i,
	input wire logic data_shift_state_i,
	input wire logic test_data_out_i,
	output logic test_clock_o,
	output logic test_mode_o,
	output logic test_data_in_o,
	// Timer
	input wire logic timer0_compare_en_a_i,
	input wire logic timer0_compare_out_a_i,
	input wire logic timer0_compare_en_b_i,
	input wire logic timer0_compare_out_b_i,
	output logic timer0_external_count_input_o,
	// Pin change sources
	output logic [7:0] pin_change_a_o,
	output logic [7:0] pin_change_b_o
);
	if (HV_W < 1 || HV_W > 8)
	begin
		$error("gpio_ports high-voltage width must be 1 to 8");
	end

	// Register state
	logic [7:0] pa_dir_r;
	logic [7:0] pa_data_r;
	logic [7:0] pb_dir_r;
	logic [7:0] pb_data_r;
	logic [1:0] pd_dir_r;
	logic [1:0] pd_data_r;
	logic [HV_W-1:0] pc_data_r;
	logic [7:0] core_ctrl_r;

	// Next values
	logic [7:0] pa_dir_nxt;
	logic [7:0] pa_data_nxt;
	logic [7:0] pb_dir_nxt;
	logic [7:0] pb_data_nxt;
	logic [7:0] pd_dir_nxt;
	logic [7:0] pd_data_nxt;
	logic [7:0] pc_data_nxt;
	logic [7:0] core_ctrl_nxt;
	logic [7:0] rdata_nxt;

	// Synchronised pins
	logic [7:0] pa_lvl;
	logic [7:0] pb_lvl;
	logic [1:0] pd_lvl;

	// Resolved controls
	logic [7:0] pa_oe;
	logic [7:0] pa_out;
	logic [7:0] pa_pu;
	logic [7:0] pa_die;
	logic [7:0] pb_oe;
	logic [7:0] pb_out;
	logic [7:0] pb_pu;
	logic [7:0] pb_die;
	logic [1:0] pd_oe;
	logic [1:0] pd_out;
	logic [1:0] pd_pu;
	logic [1:0] pd_die;

	io_pkg::pin_override_t pb_ovr;
	io_pkg::pin_override_t no_ovr;
	logic pullup_disable;
	logic tae;
	logic tdo_drive;
	logic [7:0] pc_wide;

	// One bus request, handed to the register update as a whole
	typedef struct packed {
		logic [5:0] addr;
		logic wr;
		logic bit_set;
		logic bit_clr;
		logic [2:0] idx;
		logic [7:0] wdata;
	} bus_req_t;
	bus_req_t bus_req;

	// Next value of one register under a byte write or a single-bit operation
	// The request is an argument: ports read from inside the function would be
	// invisible to the sensitivity of the assigns that call it
	function automatic logic [7:0] reg_next(
		input logic [7:0] cur,
		input logic [5:0] addr,
		input logic [7:0] mask,
		input bus_req_t req
	);
		logic [7:0] bit_sel;
		logic [7:0] res;
		bit_sel = 8'h01 << req.idx;
		res = cur;
		if (req.addr == addr)
		begin
			if (req.wr)
				res = req.wdata;
			else if (req.bit_set)
				res = cur | bit_sel;
			else if (req.bit_clr)
				res = cur & ~bit_sel;
		end
		return res & mask;
	endfunction

	assign pullup_disable = core_ctrl_r[io_pkg::PUD_BIT];
	assign tae = test_access_enable_i;
	assign tdo_drive = instruction_shift_state_i | data_shift_state_i;
	assign no_ovr = '0;
	assign bus_req = '{addr: io_addr_i, wr: io_wr_i, bit_set: io_bit_set_i,
		bit_clr: io_bit_clr_i, idx: io_bit_i, wdata: io_wdata_i};

	// Port B overrides: test pins on 3..0, compare outputs on 7..6
	always_comb
	begin
		pb_ovr = '0;
		pb_ovr.pullup_override_enable[3:0] = {4{tae}};
		pb_ovr.direction_override_enable[3:0] = {4{tae}};
		pb_ovr.input_enable_override_enable[3:0] = {4{tae}};
		pb_ovr.pullup_override_value[io_pkg::PIN_TCK] = 1'b1;
		pb_ovr.pullup_override_value[io_pkg::PIN_TMS] = 1'b1;
		pb_ovr.pullup_override_value[io_pkg::PIN_TDI] = 1'b1;
		pb_ovr.pullup_override_value[io_pkg::PIN_TDO] = 1'b0;
		pb_ovr.direction_override_value[io_pkg::PIN_TDO] = tdo_drive;
		pb_ovr.value_override_enable[io_pkg::PIN_TDO] = tae;
		pb_ovr.value_override_value[io_pkg::PIN_TDO] = test_data_out_i;
		pb_ovr.value_override_enable[io_pkg::PIN_OC_A] = timer0_compare_en_a_i;
		pb_ovr.value_override_value[io_pkg::PIN_OC_A] = timer0_compare_out_a_i;
		pb_ovr.value_override_enable[io_pkg::PIN_OC_B] = timer0_compare_en_b_i;
		pb_ovr.value_override_value[io_pkg::PIN_OC_B] = timer0_compare_out_b_i;
	end

	// Direction stays with software on compare pins, so the output needs it set
	port_pin_ctrl #(.W(8)) u_ctrl_a (
		.dir_i(pa_dir_r),
		.data_i(pa_data_r),
		.pullup_disable_i(pullup_disable),
		.ovr_i(no_ovr),
		.oe_o(pa_oe),
		.out_o(pa_out),
		.pu_o(pa_pu),
		.die_o(pa_die)
	);

	port_pin_ctrl #(.W(8)) u_ctrl_b (
		.dir_i(pb_dir_r),
		.data_i(pb_data_r),
		.pullup_disable_i(pullup_disable),
		.ovr_i(pb_ovr),
		.oe_o(pb_oe),
		.out_o(pb_out),
		.pu_o(pb_pu),
		.die_o(pb_die)
	);

	// Count source on pin 0 takes the level only, no override
	port_pin_ctrl #(.W(2)) u_ctrl_d (
		.dir_i(pd_dir_r),
		.data_i(pd_data_r),
		.pullup_disable_i(pullup_disable),
		.ovr_i(no_ovr),
		.oe_o(pd_oe),
		.out_o(pd_out),
		.pu_o(pd_pu),
		.die_o(pd_die)
	);

	pin_sync #(.W(8)) u_sync_a (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.pin_i(pa_in_i),
		.level_o(pa_lvl)
	);

	pin_sync #(.W(8)) u_sync_b (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.pin_i(pb_in_i),
		.level_o(pb_lvl)
	);

	pin_sync #(.W(2)) u_sync_d (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.ce_i(ce_i),
		.pin_i(pd_in_i),
		.level_o(pd_lvl)
	);

	// Register next values; pin registers take no writes
	assign pa_dir_nxt = reg_next(pa_dir_r, io_pkg::ADDR_A_DIR, io_pkg::MASK_FULL, bus_req);
	assign pa_data_nxt = reg_next(pa_data_r, io_pkg::ADDR_A_DATA, io_pkg::MASK_FULL, bus_req);
	assign pb_dir_nxt = reg_next(pb_dir_r, io_pkg::ADDR_B_DIR, io_pkg::MASK_FULL,
		bus_req);
	assign pb_data_nxt = reg_next(pb_data_r, io_pkg::ADDR_B_DATA, io_pkg::MASK_FULL,
		bus_req);
	assign pd_dir_nxt = reg_next({6'h00, pd_dir_r}, io_pkg::ADDR_D_DIR,
		io_pkg::MASK_PORT_D, bus_req);
	assign pd_data_nxt = reg_next({6'h00, pd_data_r}, io_pkg::ADDR_D_DATA,
		io_pkg::MASK_PORT_D, bus_req);
	assign pc_wide = {{(8-HV_W){1'b0}}, pc_data_r};
	// Bit operations touch only the selected bit of the high-voltage port
	assign pc_data_nxt = reg_next(pc_wide, io_pkg::ADDR_C_DATA,
		io_pkg::MASK_FULL, bus_req);
	assign core_ctrl_nxt = reg_next(core_ctrl_r, io_pkg::ADDR_CORE_CTRL,
		io_pkg::MASK_CORE_CTRL, bus_req);

	// Read mux; disabled digital inputs read as zero
	always_comb
	begin
		case (io_addr_i)
			io_pkg::ADDR_A_PINS: rdata_nxt = pa_lvl & pa_die;
			io_pkg::ADDR_A_DIR: rdata_nxt = pa_dir_r;
			io_pkg::ADDR_A_DATA: rdata_nxt = pa_data_r;
			io_pkg::ADDR_B_PINS: rdata_nxt = pb_lvl & pb_die;
			io_pkg::ADDR_B_DIR: rdata_nxt = pb_dir_r;
			io_pkg::ADDR_B_DATA: rdata_nxt = pb_data_r;
			io_pkg::ADDR_C_DATA: rdata_nxt = pc_wide;
			io_pkg::ADDR_D_PINS: rdata_nxt = {6'h00, pd_lvl & pd_die};
			io_pkg::ADDR_D_DIR: rdata_nxt = {6'h00, pd_dir_r};
			io_pkg::ADDR_D_DATA: rdata_nxt = {6'h00, pd_data_r};
			io_pkg::ADDR_CORE_CTRL: rdata_nxt = core_ctrl_r;
			default: rdata_nxt = io_pkg::READ_UNMAPPED;
		endcase
	end

	// Register file
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pa_dir_r <= io_pkg::RST_PORT;
			pa_data_r <= io_pkg::RST_PORT;
			pb_dir_r <= io_pkg::RST_PORT;
			pb_data_r <= io_pkg::RST_PORT;
			pd_dir_r <= io_pkg::RST_PORT[1:0];
			pd_data_r <= io_pkg::RST_PORT[1:0];
			pc_data_r <= io_pkg::RST_PORT[HV_W-1:0];
			core_ctrl_r <= io_pkg::RST_CORE_CTRL;
			io_rdata_o <= io_pkg::READ_UNMAPPED;
		end
		else if (ce_i)
		begin
			pa_dir_r <= pa_dir_nxt;
			pa_data_r <= pa_data_nxt;
			pb_dir_r <= pb_dir_nxt;
			pb_data_r <= pb_data_nxt;
			pd_dir_r <= pd_dir_nxt[1:0];
			pd_data_r <= pd_data_nxt[1:0];
			pc_data_r <= pc_data_nxt[HV_W-1:0];
			core_ctrl_r <= core_ctrl_nxt;
			if (io_rd_i)
				io_rdata_o <= rdata_nxt;
		end
	end

	// Pad drive registers; the async reset releases every pad at once
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pa_drive_o <= '0;
			pb_drive_o <= '0;
			pd_drive_o <= '0;
			pc_out_o <= '0;
			pc_oe_o <= '0;
			core_control_o <= io_pkg::RST_CORE_CTRL;
		end
		else if (ce_i)
		begin
			pa_drive_o <= '{out: pa_out, oe: pa_oe, pu: pa_pu};
			pb_drive_o <= '{out: pb_out, oe: pb_oe, pu: pb_pu};
			pd_drive_o <= '{out: {6'h00, pd_out}, oe: {6'h00, pd_oe}, pu: {6'h00, pd_pu}};
			// Open collector: only ever drives low
			pc_out_o <= '0;
			pc_oe_o <= pc_data_r;
			core_control_o <= core_ctrl_r;
		end
	end

	// Alternate-function inputs, taken from the synchroniser; test inputs gated by test access enable, the rest regardless of ownership
	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			test_clock_o <= 1'b0;
			test_mode_o <= 1'b0;
			test_data_in_o <= 1'b0;
			timer0_external_count_input_o <= 1'b0;
			pin_change_a_o <= '0;
			pin_change_b_o <= '0;
		end
		else if (ce_i)
		begin
			test_clock_o <= tae & pb_lvl[io_pkg::PIN_TCK];
			test_mode_o <= tae & pb_lvl[io_pkg::PIN_TMS];
			test_data_in_o <= tae & pb_lvl[io_pkg::PIN_TDI];
			timer0_external_count_input_o <= pd_lvl[io_pkg::PIN_T0];
			pin_change_a_o <= pa_lvl;
			pin_change_b_o <= pb_lvl;
		end
	end
endmodule
`default_nettype wire

// File: gpio_ports_checker.sv
// Port-level assertions for the port pin block
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_checker #(
	parameter int HV_W = 4
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Bus side
	input wire logic io_rd_i,
	input wire logic [7:0] io_rdata_o,
	input wire logic [7:0] core_control_o,
	// Pads
	input wire logic [7:0] pb_in_i,
	input wire logic [7:0] pin_change_b_o,
	input wire io_pkg::pin_drive_t pa_drive_o,
	input wire io_pkg::pin_drive_t pb_drive_o,
	input wire io_pkg::pin_drive_t pd_drive_o,
	input wire logic [HV_W-1:0] pc_out_o,
	// Alternate functions
	input wire logic test_access_enable_i,
	input wire logic instruction_shift_state_i,
	input wire logic data_shift_state_i,
	input wire logic test_data_out_i,
	input wire logic timer0_compare_en_a_i,
	input wire logic timer0_compare_out_a_i,
	input wire logic timer0_compare_en_b_i,
	input wire logic timer0_compare_out_b_i
);
	default clocking ck @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);
	// Set once an edge has passed out of reset, so $past never sees reset-time inputs
	logic live_r;
	wire logic tap_on = test_access_enable_i & ce_i;
	always_ff @(posedge mclk_i or negedge arst_n_i)
		if (!arst_n_i)
			live_r <= 1'b0;
		else
			live_r <= 1'b1;
	property p_test_pu;
		live_r && $past(tap_on) |-> pb_drive_o.pu[3:0] == 4'he;
	endproperty
	a_test_pu: assert property (p_test_pu) else $error("test pull-ups");
	property p_test_dir;
		live_r && $past(tap_on) |-> pb_drive_o.oe[3:1] == 3'h0;
	endproperty
	a_test_dir: assert property (p_test_dir) else $error("test pins not inputs");
	property p_tdo;
		live_r && $past(tap_on) |-> pb_drive_o.oe[0] == $past(instruction_shift_state_i |
			data_shift_state_i) && pb_drive_o.out[0] == $past(test_data_out_i);
	endproperty
	a_tdo: assert property (p_tdo) else $error("test data out pin");
	property p_pud;
		core_control_o[4] && $past(core_control_o[4]) |-> pa_drive_o.pu == 8'h00 &&
			pd_drive_o.pu == 8'h00 && pb_drive_o.pu[7:4] == 4'h0;
	endproperty
	a_pud: assert property (p_pud) else $error("pull-up while disabled");
	property p_pc_low;
		pc_out_o == '0;
	endproperty
	a_pc_low: assert property (p_pc_low) else $error("port C drives high");
	property p_pd_upper;
		{pd_drive_o.out[7:2], pd_drive_o.oe[7:2], pd_drive_o.pu[7:2]} == 18'h0;
	endproperty
	a_pd_upper: assert property (p_pd_upper) else $error("port D upper bits");
	property p_cmp_a;
		live_r && $past(ce_i && timer0_compare_en_a_i) |->
			pb_drive_o.out[6] == $past(timer0_compare_out_a_i);
	endproperty
	a_cmp_a: assert property (p_cmp_a) else $error("compare A value");
	property p_cmp_b;
		live_r && $past(ce_i && timer0_compare_en_b_i) |->
			pb_drive_o.out[7] == $past(timer0_compare_out_b_i);
	endproperty
	a_cmp_b: assert property (p_cmp_b) else $error("compare B value");
	property p_pcint;
		(ce_i && $stable(pb_in_i)) [*6] |-> pin_change_b_o == pb_in_i;
	endproperty
	a_pcint: assert property (p_pcint) else $error("pin change level");
	property p_rdata;
		live_r && !$past(io_rd_i && ce_i) |-> $stable(io_rdata_o);
	endproperty
	a_rdata: assert property (p_rdata) else $error("read data moved");
	c_shift: cover property (tap_on && data_shift_state_i);
	c_cmp: cover property (timer0_compare_en_b_i && timer0_compare_out_b_i);
	c_pud: cover property (core_control_o[4]);
endmodule

bind gpio_ports gpio_ports_checker #(.HV_W(HV_W)) i_gpio_ports_checker (.mclk_i, .arst_n_i,
	.ce_i, .io_rd_i, .io_rdata_o, .core_control_o, .pb_in_i, .pin_change_b_o, .pa_drive_o,
	.pb_drive_o, .pd_drive_o, .pc_out_o, .test_access_enable_i, .instruction_shift_state_i,
	.data_shift_state_i, .test_data_out_i, .timer0_compare_en_a_i, .timer0_compare_out_a_i,
	.timer0_compare_en_b_i, .timer0_compare_out_b_i);
`default_nettype wire

// File: gpio_ports_tb.sv
// Self-checking bench for the port pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module gpio_ports_tb;
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} row_t;
	localparam row_t ROWS [11] = '{{6'h05, 8'ha5, 8'ha5}, {6'h04, 8'h3c, 8'h3c},
		{6'h02, 8'h5a, 8'h5a}, {6'h01, 8'hc3, 8'hc3}, {6'h0b, 8'hff, 8'h03},
		{6'h0a, 8'hfe, 8'h02}, {6'h08, 8'h05, 8'h05}, {6'h35, 8'hff, 8'h93},
		{6'h35, 8'h00, 8'h00}, {6'h3f, 8'h77, 8'h00}, {6'h03, 8'hff, 8'h24}};
	logic [5:0] rst_addr [5] = '{6'h04, 6'h05, 6'h0a, 6'h0b, 6'h35};
	int err_count = 0;
	int checks = 0;
	logic [7:0] v;
	logic mclk_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1, io_wr_i = 1'b0, io_rd_i = 1'b0;
	logic io_bit_set_i = 1'b0, io_bit_clr_i = 1'b0, test_access_enable_i = 1'b0;
	logic instruction_shift_state_i = 1'b0, data_shift_state_i = 1'b0;
	logic test_data_out_i = 1'b0, timer0_compare_en_a_i = 1'b0, timer0_compare_out_a_i = 1'b0;
	logic timer0_compare_en_b_i = 1'b0, timer0_compare_out_b_i = 1'b0;
	logic [5:0] io_addr_i = 6'h00;
	logic [7:0] io_wdata_i = 8'h00, io_rdata_o, core_control_o, pa_in_i, pb_in_i, pd_lvl;
	logic [7:0] eb_en = 8'hff, eb = 8'h00, ed_en = 8'hff, ed = 8'h00;
	logic [7:0] pin_change_a_o, pin_change_b_o;
	logic [2:0] io_bit_i = 3'h0;
	logic [3:0] pc_out_o, pc_oe_o;
	logic test_clock_o, test_mode_o, test_data_in_o, timer0_external_count_input_o;
	io_pkg::pin_drive_t pa_drive_o, pb_drive_o, pd_drive_o;
	wire logic [1:0] pd_in_i = pd_lvl[1:0];
	gpio_ports i_gpio_ports (.mclk_i, .arst_n_i, .ce_i, .io_addr_i, .io_wr_i, .io_rd_i,
		.io_wdata_i, .io_bit_set_i, .io_bit_clr_i, .io_bit_i, .io_rdata_o, .core_control_o,
		.pa_in_i, .pa_drive_o, .pb_in_i, .pb_drive_o, .pd_in_i, .pd_drive_o, .pc_out_o,
		.pc_oe_o, .test_access_enable_i, .instruction_shift_state_i, .data_shift_state_i,
		.test_data_out_i, .test_clock_o, .test_mode_o, .test_data_in_o,
		.timer0_compare_en_a_i, .timer0_compare_out_a_i, .timer0_compare_en_b_i,
		.timer0_compare_out_b_i, .timer0_external_count_input_o, .pin_change_a_o,
		.pin_change_b_o);
	pad_model i_pad_a (.mclk_i, .drv_i(pa_drive_o), .ext_en_i(8'hff), .ext_i(8'h00),
		.lvl_o(pa_in_i));
	pad_model i_pad_b (.mclk_i, .drv_i(pb_drive_o), .ext_en_i(eb_en), .ext_i(eb),
		.lvl_o(pb_in_i));
	pad_model i_pad_d (.mclk_i, .drv_i(pd_drive_o), .ext_en_i(ed_en), .ext_i(ed),
		.lvl_o(pd_lvl));
	always #25 mclk_i = ~mclk_i;
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic do_reset();
		arst_n_i = 1'b0;
		tick(6);
		arst_n_i = 1'b1;
		tick(1);
	endtask
	// Strobes drop and an idle edge follows, so back-to-back calls never re-drive a strobe
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		tick(1);
		io_wr_i = 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [5:0] a);
		io_addr_i = a;
		io_rd_i = 1'b1;
		tick(1);
		io_rd_i = 1'b0;
		tick(1);
		v = io_rdata_o;
	endtask
	task automatic bop(input logic [2:0] b, input logic s);
		io_addr_i = io_pkg::ADDR_C_DATA;
		io_bit_i = b;
		io_bit_set_i = s;
		io_bit_clr_i = !s;
		tick(1);
		io_bit_set_i = 1'b0;
		io_bit_clr_i = 1'b0;
		tick(1);
	endtask
	task automatic complete_run();
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#(50 * 3000);
		err_count++;
		complete_run();
	end
	initial
	begin
		do_reset();
		`CHK("pads after reset", 24'h0, pb_drive_o)
		foreach (rst_addr[i])
		begin
			rd(rst_addr[i]);
			`CHK("reset value", 8'h00, v)
		end
		for (int i = 0; i < 11; i++)
		begin
			wr(ROWS[i].addr, ROWS[i].wdata);
			rd(ROWS[i].addr);
			`CHK("register", ROWS[i].exp, v)
		end
		`CHK("port A pads", 24'h5ac318, pa_drive_o)
		`CHK("port A pin change", 8'h42, pin_change_a_o)
		`CHK("port C pads", 8'h50, {pc_oe_o, pc_out_o})
		bop(3'h1, 1'b1);
		bop(3'h0, 1'b0);
		rd(io_pkg::ADDR_C_DATA);
		`CHK("port C bit ops", 12'h606, {pc_oe_o, v})
		arst_n_i = 1'b0;
		#1;
		`CHK("port C in reset", 4'h0, pc_oe_o)
		do_reset();
		eb = 8'h96;
		tick(6);
		rd(io_pkg::ADDR_B_PINS);
		`CHK("pin levels", 8'h96, v)
		`CHK("pin change", 4'h6, pin_change_b_o[3:0])
		eb_en = 8'h0f;
		eb = 8'h0a;
		wr(6'h05, 8'hff);
		`CHK("pull-ups", 8'hff, pb_drive_o.pu)
		wr(6'h04, 8'h80);
		`CHK("pull-ups", 8'h7f, pb_drive_o.pu)
		wr(6'h35, 8'h10);
		`CHK("pull-ups", 8'h00, pb_drive_o.pu)
		`CHK("core control", 8'h10, core_control_o)
		wr(6'h04, 8'hff);
		test_access_enable_i = 1'b1;
		tick(7);
		`CHK("test pull-ups", 8'h0e, pb_drive_o.pu)
		`CHK("test dirs", 8'hf0, pb_drive_o.oe)
		`CHK("test ins", 3'h5, {test_clock_o, test_mode_o, test_data_in_o})
		`CHK("pin change", 4'ha, pin_change_b_o[3:0])
		rd(io_pkg::ADDR_B_PINS);
		`CHK("test pin read", 8'hf0, v)
		data_shift_state_i = 1'b1;
		test_data_out_i = 1'b1;
		tick(1);
		`CHK("data shift", 2'h3, {pb_drive_o.oe[0], pb_drive_o.out[0]})
		data_shift_state_i = 1'b0;
		instruction_shift_state_i = 1'b1;
		test_data_out_i = 1'b0;
		tick(1);
		`CHK("ir shift", 2'h2, {pb_drive_o.oe[0], pb_drive_o.out[0]})
		instruction_shift_state_i = 1'b0;
		test_access_enable_i = 1'b0;
		tick(1);
		`CHK("released", 8'hff, pb_drive_o.oe)
		wr(6'h35, 8'h00);
		wr(6'h04, 8'hc0);
		timer0_compare_en_a_i = 1'b1;
		timer0_compare_en_b_i = 1'b1;
		timer0_compare_out_b_i = 1'b1;
		wr(6'h05, 8'h00);
		`CHK("compare", 2'h2, pb_drive_o.out[7:6])
		timer0_compare_en_a_i = 1'b0;
		timer0_compare_en_b_i = 1'b0;
		// Enable low must freeze the register file and the pad registers alike
		ce_i = 1'b0;
		wr(6'h05, 8'h55);
		`CHK("frozen pads", 2'h2, pb_drive_o.out[7:6])
		ce_i = 1'b1;
		rd(6'h05);
		`CHK("frozen data", 8'h00, v)
		ed = 8'h01;
		tick(7);
		`CHK("count input", 1'b1, timer0_external_count_input_o)
		`CHK("port D pads", 24'h0, pd_drive_o)
		rd(io_pkg::ADDR_D_PINS);
		`CHK("port D pins", 8'h01, v)
		complete_run();
	end
endmodule
`default_nettype wire

// File: io_pkg.sv
// Shared constants and carrier types for the port pin block
package io_pkg;
	// I/O addresses
	localparam logic [5:0] ADDR_A_PINS = 6'h00;
	localparam logic [5:0] ADDR_A_DIR = 6'h01;
	localparam logic [5:0] ADDR_A_DATA = 6'h02;
	localparam logic [5:0] ADDR_B_PINS = 6'h03;
	localparam logic [5:0] ADDR_B_DIR = 6'h04;
	localparam logic [5:0] ADDR_B_DATA = 6'h05;
	localparam logic [5:0] ADDR_C_DATA = 6'h08;
	localparam logic [5:0] ADDR_D_PINS = 6'h09;
	localparam logic [5:0] ADDR_D_DIR = 6'h0a;
	localparam logic [5:0] ADDR_D_DATA = 6'h0b;
	localparam logic [5:0] ADDR_CORE_CTRL = 6'h35;
	// Reset values and implemented-bit masks
	localparam logic [7:0] RST_PORT = 8'h00;
	localparam logic [7:0] RST_CORE_CTRL = 8'h00;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_PORT_D = 8'h03;
	localparam logic [7:0] MASK_CORE_CTRL = 8'h93;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Field positions
	localparam int PUD_BIT = 4;
	localparam int PIN_TCK = 3;
	localparam int PIN_TMS = 2;
	localparam int PIN_TDI = 1;
	localparam int PIN_TDO = 0;
	localparam int PIN_OC_A = 6;
	localparam int PIN_OC_B = 7;
	localparam int PIN_T0 = 0;
	localparam int SYNC_STAGES = 3;

	// Override signals for one 8-pin port
	typedef struct packed {
		logic [7:0] pullup_override_enable;
		logic [7:0] pullup_override_value;
		logic [7:0] direction_override_enable;
		logic [7:0] direction_override_value;
		logic [7:0] value_override_enable;
		logic [7:0] value_override_value;
		logic [7:0] input_enable_override_enable;
		logic [7:0] input_enable_override_value;
	} pin_override_t;

	// What a port drives onto its pads
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
	} pin_drive_t;
endpackage

// File: pad_model.sv
// Pad model: resolves each pad from device drive, pull-up and outside driver
`timescale 1ns/1ps
`default_nettype none
module pad_model (
	// Clock
	input wire logic mclk_i,
	// Device drive and outside world
	input wire io_pkg::pin_drive_t drv_i,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_i,
	// Pad levels
	output logic [7:0] lvl_o
);
	logic [7:0] last_r = 8'h00;
	// A floating pad without pull-up flips every cycle so a stale level never reads as valid
	assign lvl_o = (drv_i.oe & drv_i.out) | (~drv_i.oe & ext_en_i & ext_i) |
		(~drv_i.oe & ~ext_en_i & (drv_i.pu | ~last_r));
	always_ff @(posedge mclk_i)
		last_r <= lvl_o;
endmodule
`default_nettype wire

// File: pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 8
) (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic ce_i,
	// Pins and synchronised levels
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] level_nxt;

	if (W < 1 || W > 8)
	begin
		$error("pin_sync width must be 1 to 8");
	end

	// A change only counts once stages two and three agree
	assign level_nxt = (s2_r == s3_r) ? s3_r : level_o;

	always_ff @(posedge mclk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			level_o <= '0;
		end
		else if (ce_i)
		begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_o <= level_nxt;
		end
	end
endmodule
`default_nettype wire

// File: port_pin_ctrl.sv
// Per-pin resolution of port registers against alternate-function overrides
`timescale 1ns/1ps
`default_nettype none
module port_pin_ctrl #(
	parameter int W = 8
) (
	// Port registers
	input wire logic [W-1:0] dir_i,
	input wire logic [W-1:0] data_i,
	input wire logic pullup_disable_i,
	// Overrides
	input wire io_pkg::pin_override_t ovr_i,
	// Resolved pad controls
	output logic [W-1:0] oe_o,
	output logic [W-1:0] out_o,
	output logic [W-1:0] pu_o,
	output logic [W-1:0] die_o
);
	if (W < 1 || W > 8)
	begin
		$error("port_pin_ctrl width must be 1 to 8");
	end

	for (genvar n = 0; n < W; n++)
	begin : g_pin
		// Override pull-up ignores direction, data and the global disable
		assign pu_o[n] = ovr_i.pullup_override_enable[n] ? ovr_i.pullup_override_value[n]
			: (!dir_i[n] && data_i[n] && !pullup_disable_i);
		assign oe_o[n] = ovr_i.direction_override_enable[n] ? ovr_i.direction_override_value[n] : dir_i[n];
		assign out_o[n] = ovr_i.value_override_enable[n] ? ovr_i.value_override_value[n] : data_i[n];
		assign die_o[n] = ovr_i.input_enable_override_enable[n] ? ovr_i.input_enable_override_value[n] : 1'b1;
	end
endmodule
`default_nettype wire
